// ### verilog/pvs_pkg.sv
package pvs_pkg;

	// Register addresses on the management interface
	localparam logic [4:0] REG_CFG   = 5'h12;
	localparam logic [4:0] REG_INT   = 5'h15;
	localparam logic [4:0] REG_RXERR = 5'h16;
	localparam logic [4:0] REG_DISC  = 5'h17;

	// Configuration/status register fields
	localparam int CFG_LINK_PULSE = 14;
	localparam int CFG_HEARTBEAT  = 13;
	localparam int CFG_SQUELCH    = 12;
	localparam int CFG_JABBER     = 11;
	localparam int CFG_SERIAL     = 10;
	localparam int CFG_POLARITY   = 0;

	// Interrupt register fields
	localparam int INT_PENDING     = 15;
	localparam int INT_DUPLEX_MASK = 11;
	localparam int INT_SPEED_MASK  = 10;
	localparam int INT_LINK_MASK   = 9;
	localparam int INT_MASTER_MASK = 8;
	localparam int INT_DUPLEX_CHG  = 4;
	localparam int INT_SPEED_CHG   = 3;
	localparam int INT_LINK_CHG    = 2;
	localparam int INT_STATUS      = 0;

	// Values after reset
	localparam logic RST_LINK_PULSE = 1'b1;
	localparam logic RST_HEARTBEAT  = 1'b1;
	localparam logic RST_SQUELCH    = 1'b1;
	localparam logic RST_JABBER     = 1'b1;
	localparam logic RST_SERIAL     = 1'b0;
	localparam logic RST_MASK       = 1'b1;

	// Management frame layout, in clock-edge counts
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [4:0] HDR_LAST      = 5'h0b;
	localparam logic [4:0] WR_LAST       = 5'h11;
	localparam logic [4:0] RD_LAST       = 5'h11;
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_WRITE      = 2'h1;

endpackage

// ### verilog/pvs_mdio.sv
`timescale 1ns/1ps
module pvs_mdio (
	input  wire logic        clk,       // Device clock
	input  wire logic        nrst,      // Async reset, active low
	input  wire logic        mdc,       // Management clock pin
	input  wire logic        mdio_i,    // Management data pin in
	input  wire logic [4:0]  phy_addr,  // Address strap pins
	input  wire logic [15:0] rd_data,   // Read value of addressed reg
	input  wire logic        rd_hit,    // Address belongs to this block
	output logic             mdio_o,    // Management data out
	output logic             mdio_oe,   // Management data enable
	output logic             rd_stb,    // Read request pulse
	output logic             wr_stb,    // Write request pulse
	output logic [4:0]       reg_addr,  // Register address of frame
	output logic [15:0]      wr_data    // Write value
);
	typedef enum logic [2:0] {
		PVS_PRE, PVS_START, PVS_HDR, PVS_RD, PVS_WR
	} pvs_mdio_state_e;

	pvs_mdio_state_e state_r;
	logic [2:0]  mdc_sync_r;
	logic [1:0]  mdio_sync_r;
	logic [4:0]  addr_s1_r;
	logic [4:0]  addr_s2_r;
	logic [5:0]  ones_r;
	logic [4:0]  cnt_r;
	logic [15:0] sh_r;
	logic        hit_r;
	logic        bit_in;
	logic        edge_rise;
	logic [15:0] sh_in;

	// Pins pass two flops; the third only delays mdc for edge finding
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			mdc_sync_r  <= 3'h0;
			mdio_sync_r <= 2'h0;
			addr_s1_r   <= 5'h00;
			addr_s2_r   <= 5'h00;
		end
		else
		begin
			mdc_sync_r  <= {mdc_sync_r[1:0], mdc};
			mdio_sync_r <= {mdio_sync_r[0], mdio_i};
			addr_s1_r   <= phy_addr;
			addr_s2_r   <= addr_s1_r;
		end

	assign edge_rise = mdc_sync_r[1] & ~mdc_sync_r[2];
	assign bit_in    = mdio_sync_r[1];
	assign sh_in     = {sh_r[14:0], bit_in};

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			state_r  <= PVS_PRE;
			ones_r   <= 6'h00;
			cnt_r    <= 5'h00;
			sh_r     <= 16'h0000;
			hit_r    <= 1'b0;
			mdio_o   <= 1'b0;
			mdio_oe  <= 1'b0;
			rd_stb   <= 1'b0;
			wr_stb   <= 1'b0;
			reg_addr <= 5'h00;
			wr_data  <= 16'h0000;
		end
		else
		begin
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (state_r == PVS_RD && rd_stb)
			begin
				sh_r  <= rd_data;
				hit_r <= rd_hit;
			end
			if (edge_rise)
			begin
				unique case (state_r)
					PVS_PRE:
						if (bit_in)
						begin
							if (ones_r != pvs_pkg::PREAMBLE_ONES)
								ones_r <= ones_r + 6'h01;
						end
						else if (ones_r == pvs_pkg::PREAMBLE_ONES)
							state_r <= PVS_START;
						else
							ones_r <= 6'h00;
					PVS_START:
					begin
						ones_r  <= 6'h00;
						cnt_r   <= 5'h00;
						state_r <= bit_in ? PVS_HDR : PVS_PRE;
					end
					PVS_HDR:
					begin
						sh_r  <= sh_in;
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == pvs_pkg::HDR_LAST)
						begin
							cnt_r    <= 5'h00;
							reg_addr <= sh_in[4:0];
							state_r  <= PVS_PRE;
							if (sh_in[9:5] == addr_s2_r)
							begin
								if (sh_in[11:10] == pvs_pkg::OP_READ)
								begin
									state_r <= PVS_RD;
									rd_stb  <= 1'b1;
								end
								else if (sh_in[11:10] == pvs_pkg::OP_WRITE)
									state_r <= PVS_WR;
							end
						end
					end
					PVS_RD:
					begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == 5'h00)
						begin
							mdio_oe <= hit_r;
							mdio_o  <= 1'b0;
						end
						else if (cnt_r == pvs_pkg::RD_LAST)
						begin
							mdio_oe <= 1'b0;
							mdio_o  <= 1'b0;
							state_r <= PVS_PRE;
						end
						else
						begin
							mdio_o <= sh_r[15];
							sh_r   <= {sh_r[14:0], 1'b0};
						end
					end
					PVS_WR:
					begin
						sh_r  <= sh_in;
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == pvs_pkg::WR_LAST)
						begin
							wr_data <= sh_in;
							wr_stb  <= 1'b1;
							state_r <= PVS_PRE;
						end
					end
				endcase
			end
		end
endmodule

// ### verilog/pvs_phy_vendor_status_regs.sv
// What this block does
// - Link pulse enable resets 1; at 0 pulses stop and link forced good at 10M only
// - Heartbeat enable resets 1; ignored while running full duplex
// - Squelch bit resets 1; 1 normal threshold, 0 low threshold
// - Jabber enable resets 1; acts in 10M full duplex or loopback
// - Serial select resets 0 (nibble); 1 picks seven-wire, never at 100M
// - Reserved configuration bits read zero and ignore writes
// - Polarity flag resets 0, follows reversed polarity seen at 10M
// - Pending bit mirrors interrupt status; interrupt register read clears
// - Duplex change mask resets 1 and blocks duplex change interrupts
// - Speed change mask resets 1 and blocks speed change interrupts
// - Link change mask resets 1 and blocks link change interrupts
// - Master mask resets 1 and blocks every interrupt
// - Duplex change flag latches on change, cleared by interrupt read
// - Speed change flag latches on change, cleared by interrupt read
// - Link change flag latches on change, cleared by interrupt read
// - Status is set when master clear and an unmasked flag set
// - 16-bit receive error counter resets zero, counts each error
// - 8-bit disconnect counter in low byte; upper byte reads zero
`timescale 1ns/1ps
module pvs_phy_vendor_status_regs #(
	parameter int RXERR_W = 16,
	parameter int DISC_W  = 8
) (
	input  wire logic       clk,                    // 40 MHz clock
	input  wire logic       nrst,                   // Async reset, low
	input  wire logic       mdc,                    // Management clock
	input  wire logic       mdio_i,                 // Management data in
	input  wire logic [4:0] phy_addr,               // Address straps
	input  wire logic       full_duplex,            // Running full duplex
	input  wire logic       speed_100,              // Running at 100M
	input  wire logic       loopback,               // Transceiver loopback
	input  wire logic       duplex_status,          // Current duplex
	input  wire logic       speed_status,           // Current speed
	input  wire logic       link_status,            // Current link
	input  wire logic       polarity_reversed_in,   // Receiver sees reversal
	input  wire logic       receive_error_event,    // One-cycle error pulse
	input  wire logic       disconnect_event,       // One-cycle pulse
	output logic            mdio_o,                 // Management data out
	output logic            mdio_oe,                // Management data enable
	output logic            link_pulse_send,        // Send link pulses
	output logic            link_good_forced,       // Force good link
	output logic            heartbeat_on,           // Heartbeat active
	output logic            squelch_low,            // Low squelch level
	output logic            jabber_on,              // Jabber function on
	output logic            seven_wire_serial_mode, // Serial MAC interface
	output logic            management_interrupt_n  // Interrupt pin, low
);
	logic               rd_stb;
	logic               wr_stb;
	logic [4:0]         reg_addr;
	logic [15:0]        wr_data;
	logic [15:0]        rd_data;
	logic               rd_hit;
	logic               link_pulse_enable_r;
	logic               heartbeat_enable_r;
	logic               squelch_normal_r;
	logic               jabber_function_enable_r;
	logic               serial_mode_select_r;
	logic               polarity_reversed_flag_r;
	logic               duplex_change_mask_r;
	logic               speed_change_mask_r;
	logic               link_change_mask_r;
	logic               master_interrupt_mask_r;
	logic               duplex_change_flag_r;
	logic               speed_change_flag_r;
	logic               link_change_flag_r;
	logic               interrupt_status_flag_r;
	logic               duplex_prev_r;
	logic               speed_prev_r;
	logic               link_prev_r;
	logic               armed_r;
	logic [RXERR_W-1:0] rx_err_cnt_r;
	logic [DISC_W-1:0]  disc_cnt_r;
	logic               int_read;
	logic               duplex_chg;
	logic               speed_chg;
	logic               link_chg;
	logic               duplex_flag_nxt;
	logic               speed_flag_nxt;
	logic               link_flag_nxt;
	logic               status_nxt;

	function automatic logic latch_flag(input logic flag, input logic set,
		input logic clr);
		// A new event wins over a clearing read in the same cycle
		latch_flag = set | (flag & ~clr);
	endfunction

	function automatic logic is_ours(input logic [4:0] a);
		is_ours = (a == pvs_pkg::REG_CFG) || (a == pvs_pkg::REG_INT) ||
			(a == pvs_pkg::REG_RXERR) || (a == pvs_pkg::REG_DISC);
	endfunction

	pvs_mdio u_mdio (
		.clk      (clk),
		.nrst     (nrst),
		.mdc      (mdc),
		.mdio_i   (mdio_i),
		.phy_addr (phy_addr),
		.rd_data  (rd_data),
		.rd_hit   (rd_hit),
		.mdio_o   (mdio_o),
		.mdio_oe  (mdio_oe),
		.rd_stb   (rd_stb),
		.wr_stb   (wr_stb),
		.reg_addr (reg_addr),
		.wr_data  (wr_data)
	);

	assign int_read   = rd_stb && (reg_addr == pvs_pkg::REG_INT);
	assign duplex_chg = armed_r && (duplex_status != duplex_prev_r);
	assign speed_chg  = armed_r && (speed_status != speed_prev_r);
	assign link_chg   = armed_r && (link_status != link_prev_r);
	assign duplex_flag_nxt = latch_flag(duplex_change_flag_r, duplex_chg,
		int_read);
	assign speed_flag_nxt  = latch_flag(speed_change_flag_r, speed_chg,
		int_read);
	assign link_flag_nxt   = latch_flag(link_change_flag_r, link_chg,
		int_read);
	assign status_nxt = ~master_interrupt_mask_r &
		((duplex_flag_nxt & ~duplex_change_mask_r) |
		(speed_flag_nxt & ~speed_change_mask_r) |
		(link_flag_nxt & ~link_change_mask_r));

	// Read mux; unlisted and reserved bits stay zero
	always_comb
	begin
		rd_data = 16'h0000;
		rd_hit  = is_ours(reg_addr);
		unique case (reg_addr)
			pvs_pkg::REG_CFG:
			begin
				rd_data[pvs_pkg::CFG_LINK_PULSE] = link_pulse_enable_r;
				rd_data[pvs_pkg::CFG_HEARTBEAT]  = heartbeat_enable_r;
				rd_data[pvs_pkg::CFG_SQUELCH]    = squelch_normal_r;
				rd_data[pvs_pkg::CFG_JABBER]     = jabber_function_enable_r;
				rd_data[pvs_pkg::CFG_SERIAL]     = serial_mode_select_r;
				rd_data[pvs_pkg::CFG_POLARITY]   = polarity_reversed_flag_r;
			end
			pvs_pkg::REG_INT:
			begin
				rd_data[pvs_pkg::INT_PENDING]     = interrupt_status_flag_r;
				rd_data[pvs_pkg::INT_DUPLEX_MASK] = duplex_change_mask_r;
				rd_data[pvs_pkg::INT_SPEED_MASK]  = speed_change_mask_r;
				rd_data[pvs_pkg::INT_LINK_MASK]   = link_change_mask_r;
				rd_data[pvs_pkg::INT_MASTER_MASK] = master_interrupt_mask_r;
				rd_data[pvs_pkg::INT_DUPLEX_CHG]  = duplex_change_flag_r;
				rd_data[pvs_pkg::INT_SPEED_CHG]   = speed_change_flag_r;
				rd_data[pvs_pkg::INT_LINK_CHG]    = link_change_flag_r;
				rd_data[pvs_pkg::INT_STATUS]      = interrupt_status_flag_r;
			end
			pvs_pkg::REG_RXERR:
				rd_data[RXERR_W-1:0] = rx_err_cnt_r;
			pvs_pkg::REG_DISC:
				rd_data[DISC_W-1:0] = disc_cnt_r;
			default:
				rd_data = 16'h0000;
		endcase
	end

	// Configuration bits; reserved positions are simply not stored
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			link_pulse_enable_r      <= pvs_pkg::RST_LINK_PULSE;
			heartbeat_enable_r       <= pvs_pkg::RST_HEARTBEAT;
			squelch_normal_r         <= pvs_pkg::RST_SQUELCH;
			jabber_function_enable_r <= pvs_pkg::RST_JABBER;
			serial_mode_select_r     <= pvs_pkg::RST_SERIAL;
		end
		else if (wr_stb && reg_addr == pvs_pkg::REG_CFG)
		begin
			link_pulse_enable_r      <= wr_data[pvs_pkg::CFG_LINK_PULSE];
			heartbeat_enable_r       <= wr_data[pvs_pkg::CFG_HEARTBEAT];
			squelch_normal_r         <= wr_data[pvs_pkg::CFG_SQUELCH];
			jabber_function_enable_r <= wr_data[pvs_pkg::CFG_JABBER];
			serial_mode_select_r     <= wr_data[pvs_pkg::CFG_SERIAL];
		end

	// Mode outputs toward the 10M line logic
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			link_pulse_send          <= 1'b0;
			link_good_forced         <= 1'b0;
			heartbeat_on             <= 1'b0;
			squelch_low              <= 1'b0;
			jabber_on                <= 1'b0;
			seven_wire_serial_mode   <= 1'b0;
			polarity_reversed_flag_r <= 1'b0;
		end
		else
		begin
			link_pulse_send  <= ~speed_100 & link_pulse_enable_r;
			link_good_forced <= ~speed_100 & ~link_pulse_enable_r;
			heartbeat_on     <= heartbeat_enable_r & ~full_duplex;
			squelch_low      <= ~squelch_normal_r;
			jabber_on        <= jabber_function_enable_r & ~speed_100 &
				(full_duplex | loopback);
			seven_wire_serial_mode <= serial_mode_select_r & ~speed_100;
			polarity_reversed_flag_r <= polarity_reversed_in & ~speed_100;
		end

	// Interrupt masks
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			duplex_change_mask_r    <= pvs_pkg::RST_MASK;
			speed_change_mask_r     <= pvs_pkg::RST_MASK;
			link_change_mask_r      <= pvs_pkg::RST_MASK;
			master_interrupt_mask_r <= pvs_pkg::RST_MASK;
		end
		else if (wr_stb && reg_addr == pvs_pkg::REG_INT)
		begin
			duplex_change_mask_r    <= wr_data[pvs_pkg::INT_DUPLEX_MASK];
			speed_change_mask_r     <= wr_data[pvs_pkg::INT_SPEED_MASK];
			link_change_mask_r      <= wr_data[pvs_pkg::INT_LINK_MASK];
			master_interrupt_mask_r <= wr_data[pvs_pkg::INT_MASTER_MASK];
		end

	// Change detection; first cycle after reset only takes a reference
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			armed_r       <= 1'b0;
			duplex_prev_r <= 1'b0;
			speed_prev_r  <= 1'b0;
			link_prev_r   <= 1'b0;
		end
		else
		begin
			armed_r       <= 1'b1;
			duplex_prev_r <= duplex_status;
			speed_prev_r  <= speed_status;
			link_prev_r   <= link_status;
		end

	// Latched change flags, interrupt status and pin
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			duplex_change_flag_r    <= 1'b0;
			speed_change_flag_r     <= 1'b0;
			link_change_flag_r      <= 1'b0;
			interrupt_status_flag_r <= 1'b0;
			management_interrupt_n  <= 1'b1;
		end
		else
		begin
			duplex_change_flag_r    <= duplex_flag_nxt;
			speed_change_flag_r     <= speed_flag_nxt;
			link_change_flag_r      <= link_flag_nxt;
			interrupt_status_flag_r <= status_nxt;
			management_interrupt_n  <= ~status_nxt;
		end

	// Event counters wrap at full scale
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			rx_err_cnt_r <= '0;
			disc_cnt_r   <= '0;
		end
		else
		begin
			if (receive_error_event)
				rx_err_cnt_r <= rx_err_cnt_r + RXERR_W'(1);
			if (disconnect_event)
				disc_cnt_r <= disc_cnt_r + DISC_W'(1);
		end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_int_read;
		rd_stb && reg_addr == pvs_pkg::REG_INT;
	endsequence

	sequence s_duplex_event;
		armed_r && $changed(duplex_status);
	endsequence

	property p_master_blocks;
		master_interrupt_mask_r |=> !interrupt_status_flag_r &&
			management_interrupt_n;
	endproperty
	a_master_blocks: assert property (p_master_blocks)
		else $error("interrupt raised under master mask");

	property p_pin_follows;
		(!master_interrupt_mask_r && !link_change_mask_r && link_chg)
			|=> !management_interrupt_n ##0 interrupt_status_flag_r;
	endproperty
	a_pin_follows: assert property (p_pin_follows)
		else $error("interrupt pin not asserted for unmasked change");

	property p_duplex_latch;
		s_duplex_event |=> duplex_change_flag_r;
	endproperty
	a_duplex_latch: assert property (p_duplex_latch)
		else $error("duplex change not latched");

	property p_read_clears;
		s_int_read and (!link_chg && !speed_chg && !duplex_chg)
			|=> !link_change_flag_r && !speed_change_flag_r &&
			!duplex_change_flag_r && !interrupt_status_flag_r;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("interrupt read did not clear flags");

	property p_pending_mirror;
		(rd_hit && reg_addr == pvs_pkg::REG_INT) |->
			rd_data[pvs_pkg::INT_PENDING] == !management_interrupt_n;
	endproperty
	a_pending_mirror: assert property (p_pending_mirror)
		else $error("pending bit differs from status bit");

	property p_masked_all;
		(duplex_change_mask_r && speed_change_mask_r && link_change_mask_r)
			[*2] |-> !interrupt_status_flag_r;
	endproperty
	a_masked_all: assert property (p_masked_all)
		else $error("masked causes raised an interrupt");

	property p_rx_count;
		receive_error_event |=> rx_err_cnt_r == $past(rx_err_cnt_r) +
			RXERR_W'(1);
	endproperty
	a_rx_count: assert property (p_rx_count)
		else $error("receive error counter did not step");

	property p_disc_count;
		disconnect_event |=> disc_cnt_r == $past(disc_cnt_r) + DISC_W'(1);
	endproperty
	a_disc_count: assert property (p_disc_count)
		else $error("disconnect counter did not step");

	property p_cfg_reserved;
		(reg_addr == pvs_pkg::REG_CFG) |-> rd_data[15] == 1'b0 &&
			rd_data[9:1] == 9'h000;
	endproperty
	a_cfg_reserved: assert property (p_cfg_reserved)
		else $error("reserved configuration bits not zero");

	property p_heartbeat_fdx;
		full_duplex |=> !heartbeat_on;
	endproperty
	a_heartbeat_fdx: assert property (p_heartbeat_fdx)
		else $error("heartbeat active in full duplex");

	property p_no_serial_100;
		speed_100 |=> !seven_wire_serial_mode && !polarity_reversed_flag_r;
	endproperty
	a_no_serial_100: assert property (p_no_serial_100)
		else $error("10M-only function active at 100M");
endmodule

// ### testbench/pvs_sta.sv
`timescale 1ns/1ps
module pvs_sta #(
	parameter logic [4:0] PHY  = 5'h05, // Device address
	parameter int         HALF = 5      // Clock cycles per mdc high half; low half is one more
) (
	input  wire logic clk,     // Device clock
	input  wire logic mdio_o,  // Device data out
	input  wire logic mdio_oe, // Device drive enable
	output logic      mdc,     // Management clock
	output logic      mdio_i   // Resolved data line
);
	logic drv_en  = 1'b0;
	logic drv_bit = 1'b1;
	logic [4:0] phy_sel = PHY;

	// Line nobody drives floats high through the pull-up
	assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv_bit : 1'b1);

	// Clock stands low between frames
	initial mdc = 1'b0;

	task automatic bit_out(input logic b, input logic en,
		output logic smp);
		@(posedge clk);
		#1;
		drv_en = en;
		drv_bit = b;
		repeat (HALF) @(posedge clk);
		#1;
		mdc = 1'b1;
		repeat (HALF) @(posedge clk);
		#1;
		smp = mdio_i;
		mdc = 1'b0;
	endtask

	// Whole frame; read data found after the turnaround zero
	task automatic frame(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [13:0] hdr;
		logic [18:0] seq;
		logic [18:0] smp;
		logic        s;
		hdr = {2'b01, op, phy_sel, ra};
		seq = {2'b10, wd, 1'b1};
		for (int i = 0; i < 32; i++)
			bit_out(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--)
			bit_out(hdr[i], 1'b1, s);
		for (int i = 18; i >= 0; i--)
		begin
			bit_out(seq[i], op == pvs_pkg::OP_WRITE && i > 0, s);
			smp[i] = s;
		end
		rd = smp[18] ? smp[16:1] : smp[17:2];
	endtask
endmodule

// ### testbench/pvs_phy_vendor_status_regs_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) compare(16'(g), 16'(e))
module pvs_phy_vendor_status_regs_tb;
	localparam logic [4:0] PHY = 5'h05;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        mdc;
	logic        mdio_i;
	logic        mdio_o;
	logic        mdio_oe;
	logic        full_duplex = 1'b0;
	logic        speed_100 = 1'b0;
	logic        loopback = 1'b0;
	logic        duplex_status = 1'b0;
	logic        speed_status = 1'b0;
	logic        link_status = 1'b0;
	logic        polarity_reversed_in = 1'b0;
	logic        receive_error_event = 1'b0;
	logic        disconnect_event = 1'b0;
	logic        link_pulse_send;
	logic        link_good_forced;
	logic        heartbeat_on;
	logic        squelch_low;
	logic        jabber_on;
	logic        seven_wire_serial_mode;
	logic        management_interrupt_n;
	logic [15:0] rdat;
	logic [15:0] msk;
	logic [15:0] expv;
	int          fail_count = 0;
	int          check_count = 0;

	always #12.5 clk = ~clk;

	pvs_phy_vendor_status_regs dut (
		.clk(clk), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_i),
		.phy_addr(PHY), .full_duplex(full_duplex),
		.speed_100(speed_100), .loopback(loopback),
		.duplex_status(duplex_status), .speed_status(speed_status),
		.link_status(link_status),
		.polarity_reversed_in(polarity_reversed_in),
		.receive_error_event(receive_error_event),
		.disconnect_event(disconnect_event),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe),
		.link_pulse_send(link_pulse_send),
		.link_good_forced(link_good_forced),
		.heartbeat_on(heartbeat_on), .squelch_low(squelch_low),
		.jabber_on(jabber_on),
		.seven_wire_serial_mode(seven_wire_serial_mode),
		.management_interrupt_n(management_interrupt_n)
	);

	pvs_sta #(.PHY(PHY)) sta (
		.clk(clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
		.mdc(mdc), .mdio_i(mdio_i)
	);

	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		sta.frame(pvs_pkg::OP_WRITE, ra, d, rdat);
		step(2);
	endtask

	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		sta.frame(pvs_pkg::OP_READ, ra, 16'h0000, rdat);
		step(2);
		`CHK(rdat, exp);
	endtask

	// Status toggles for 0..2, one-cycle pulses for 3 and 4
	task automatic ev(input int k);
		case (k)
			0: duplex_status = ~duplex_status;
			1: speed_status = ~speed_status;
			2: link_status = ~link_status;
			3: receive_error_event = 1'b1;
			default: disconnect_event = 1'b1;
		endcase
		step(1);
		receive_error_event = 1'b0;
		disconnect_event = 1'b0;
		step(2);
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end

	initial
	begin
		step(16);
		nrst = 1'b1;
		step(2);
		`CHK(link_pulse_send, 1'b1);
		`CHK(heartbeat_on, 1'b1);
		`CHK(squelch_low, 1'b0);
		`CHK(seven_wire_serial_mode, 1'b0);
		rd(pvs_pkg::REG_CFG, 16'h7800);
		rd(pvs_pkg::REG_RXERR, 16'h0000);
		rd(pvs_pkg::REG_DISC, 16'h0000);
		rd(5'h00, 16'hffff);
		// Frames for another device address must be ignored
		sta.phy_sel = PHY + 5'h01;
		wr(pvs_pkg::REG_INT, 16'h0000);
		rd(pvs_pkg::REG_INT, 16'hffff);
		sta.phy_sel = PHY;
		rd(pvs_pkg::REG_INT, 16'h0f00);
		ev(2);
		`CHK(management_interrupt_n, 1'b1);
		rd(pvs_pkg::REG_INT, 16'h0f04);
		wr(pvs_pkg::REG_INT, 16'h0100);
		ev(1);
		`CHK(management_interrupt_n, 1'b1);
		wr(pvs_pkg::REG_INT, 16'h0000);
		`CHK(management_interrupt_n, 1'b0);
		rd(pvs_pkg::REG_INT, 16'h8009);
		for (int k = 0; k < 3; k++)
		begin
			msk = 16'h0800 >> k;
			wr(pvs_pkg::REG_INT, msk);
			ev(k);
			`CHK(management_interrupt_n, 1'b1);
			ev((k + 1) % 3);
			`CHK(management_interrupt_n, 1'b0);
			expv = msk | 16'h8001 | (16'h0010 >> k);
			expv = expv | (16'h0010 >> ((k + 1) % 3));
			rd(pvs_pkg::REG_INT, expv);
			`CHK(management_interrupt_n, 1'b1);
			rd(pvs_pkg::REG_INT, msk);
		end
		wr(pvs_pkg::REG_INT, 16'h0e00);
		ev(2);
		`CHK(management_interrupt_n, 1'b1);
		rd(pvs_pkg::REG_INT, 16'h0e04);
		wr(pvs_pkg::REG_CFG, 16'hffff);
		rd(pvs_pkg::REG_CFG, 16'h7c00);
		full_duplex = 1'b1;
		step(2);
		`CHK(heartbeat_on, 1'b0);
		`CHK(jabber_on, 1'b1);
		`CHK(seven_wire_serial_mode, 1'b1);
		full_duplex = 1'b0;
		loopback = 1'b1;
		speed_100 = 1'b1;
		step(2);
		`CHK(seven_wire_serial_mode, 1'b0);
		`CHK(link_pulse_send, 1'b0);
		`CHK(jabber_on, 1'b0);
		speed_100 = 1'b0;
		step(2);
		`CHK(jabber_on, 1'b1);
		wr(pvs_pkg::REG_CFG, 16'h0000);
		loopback = 1'b0;
		polarity_reversed_in = 1'b1;
		step(4);
		`CHK(link_good_forced, 1'b1);
		`CHK(link_pulse_send, 1'b0);
		`CHK(squelch_low, 1'b1);
		rd(pvs_pkg::REG_CFG, 16'h0001);
		polarity_reversed_in = 1'b0;
		rd(pvs_pkg::REG_CFG, 16'h0000);
		for (int i = 0; i < 3; i++)
			ev(3);
		for (int i = 0; i < 257; i++)
			ev(4);
		rd(pvs_pkg::REG_RXERR, 16'h0003);
		rd(pvs_pkg::REG_DISC, 16'h0001);
		nrst = 1'b0;
		step(3);
		nrst = 1'b1;
		step(2);
		rd(pvs_pkg::REG_CFG, 16'h7800);
		rd(pvs_pkg::REG_DISC, 16'h0000);
		tally_and_finish();
	end
endmodule
